// [verilog/digital_port_params.svh]
`ifndef DIGITAL_PORT_PARAMS_SVH
`define DIGITAL_PORT_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_FUNC_OFF 8'h00
`define REG_POL_OFF 8'h04
`define REG_OUT_OFF 8'h08
`define REG_IN_OFF 8'h0C
`define REG_MODE_OFF 8'h10
`define REG_OUTSET_OFF 8'h14
`define REG_CLEAR_OFF 8'h18
`define REG_STATUS_OFF 8'h1C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OUTSET_ASSIGN_BIT 0
`define CLEAR_BIT 0
`define STAT_BT_BIT 0
`define STAT_STICKY_BIT 1
`define STAT_FAULT_BIT 2
`define STAT_BLOCKED_BIT 3
`define FUNC_RESET 6'h15
`define POL_RESET 3'h0
`define OUT_RESET 3'h0
`define MODE_INVALID 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_KHZ 10000
`define BLOCK_LATENCY_US 450
`define BLOCK_LATENCY_CYC ((`BLOCK_LATENCY_US * `CLOCK_KHZ) / 1000)
`define SHUTOFF_MS 45
`define SHUTOFF_CYC (`SHUTOFF_MS * `CLOCK_KHZ)

`endif

// [verilog/digital_port_pkg.sv]
package digital_port_pkg;

	typedef enum logic [1:0] {
		general_bidir_pin_function,
		input_only_pin_function,
		fault_signal_pin_function,
		output_block_pin_function
	} pin_func_e;

	typedef enum logic [1:0] {
		block_mode_off,
		block_mode_live,
		sticky_block_mode
	} block_mode_e;

	typedef struct packed {
		logic s1;
		logic s2;
		logic drive;
		logic oe;
	} pin_state_s;

	typedef struct packed {
		logic blocked;
		logic sticky;
		logic fault;
		logic prev_true;
	} block_state_s;

	typedef struct packed {
		logic [5:0] func;
		logic [2:0] neg;
		logic [2:0] out_word;
		block_mode_e mode;
		logic loaded;
		logic wr_pend;
		logic wr_map;
		logic [7:0] wr_off;
		logic rd_pend;
		logic rd_map;
		logic [7:0] rd_off;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic clear;
		logic nv_save;
	} port_state_s;

endpackage : digital_port_pkg

// [verilog/block_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface block_if;
	import digital_port_pkg::*;
	block_mode_e mode;
	logic block_true;
	logic clear;
	logic chan_cause;
	logic blocked;
	logic sticky;
	logic fault;

	modport ctrl (input mode, input block_true, input clear, input chan_cause,
		output blocked, output sticky, output fault);
	modport top (output mode, output block_true, output clear, output chan_cause,
		input blocked, input sticky, input fault);
endinterface : block_if

`default_nettype wire

// [verilog/pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_cell
	import digital_port_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin_in,
	input wire logic neg,
	input wire logic oe_req,
	input wire logic bit_req,
	output logic pin_out,
	output logic pin_oe,
	output logic sense
);
	pin_state_s r;
	pin_state_s n;

	always_comb
	begin
		n = r;
		n.s1 = pin_in;
		n.s2 = r.s1;
		n.drive = bit_req ^ neg;
		n.oe = oe_req;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end

	assign pin_out = r.drive;
	assign pin_oe = r.oe;
	// Polarity applies to the sensed level as well as the driven one
	assign sense = r.s2 ^ neg;
endmodule : pin_cell

`default_nettype wire

// [verilog/block_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module block_ctrl
	import digital_port_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	block_if.ctrl bus
);
	block_state_s r;
	block_state_s n;

	always_comb
	begin
		n = r;
		n.prev_true = bus.block_true;
		if (bus.mode != sticky_block_mode)
			n.sticky = 1'b0;
		else if (bus.block_true && !r.prev_true)
			n.sticky = 1'b1;
		else if (bus.clear && !bus.block_true)
			n.sticky = 1'b0;
		case (bus.mode)
			block_mode_live: n.blocked = bus.block_true;
			sticky_block_mode: n.blocked = n.sticky;
			default: n.blocked = 1'b0;
		endcase
		// Set wins over clear so an event in the clear cycle is kept
		if (bus.clear && !bus.chan_cause && !n.blocked)
			n.fault = 1'b0;
		if (bus.chan_cause || n.blocked)
			n.fault = 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			r <= '0;
		else
			r <= n;
	end

	assign bus.blocked = r.blocked;
	assign bus.sticky = r.sticky;
	assign bus.fault = r.fault;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_rise_sticky;
		bus.mode == sticky_block_mode && bus.block_true && !r.prev_true;
	endsequence
	// Hold is judged on the latch itself: a live-mode block carried into sticky mode is not held
	sequence s_held_sticky;
		bus.mode == sticky_block_mode && bus.sticky && !bus.clear
			##1 bus.mode == sticky_block_mode;
	endsequence

	property p_fault_set;
		bus.chan_cause |=> bus.fault;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not raised");

	property p_fault_hold;
		bus.fault && !bus.clear |=> bus.fault;
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");

	property p_sticky_trip;
		s_rise_sticky |=> bus.blocked;
	endproperty
	a_sticky_trip: assert property (p_sticky_trip) else $error("no sticky trip");

	property p_sticky_hold;
		s_held_sticky |-> bus.blocked;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky released");

	property p_live;
		bus.mode == block_mode_live |=> bus.blocked == $past(bus.block_true);
	endproperty
	a_live: assert property (p_live) else $error("live mode wrong");

	property p_off;
		bus.mode == block_mode_off |=> !bus.blocked;
	endproperty
	a_off: assert property (p_off) else $error("off mode blocked");

	property p_clear;
		bus.clear && !bus.block_true && !bus.chan_cause |=> !bus.fault && !bus.blocked;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");
endmodule : block_ctrl

`default_nettype wire

// [verilog/digital_port.sv]
// How it works
// - Three pins, each with its own function and polarity setting.
// - Bidirectional pin drives its output bit and reports its sensed level.
// - Output word is binary weighted; value 7 sets all three pins.
// - Positive polarity: bit 1 drives high, bit 0 drives low.
// - Input word shows levels of bidirectional and input-only pins.
// - Input-only pin is never driven, whatever the output word holds.
// - Fault signal only on pin 1; pin 2 then undriven, its function ignored.
// - Fault raised by any channel protection event or a blocking trip.
// - Fault stays latched until cause gone and clear issued; polarity selectable.
// - Blocking input only on pin 3; it gates all channels together.
// - Blocking input is level sensed with latency under 450 us.
// - Channels start turning off within 45 ms of blocking input.
// - Blocking mode is saved to and restored from non-volatile storage.
// - Sticky mode: true transition blocks until clear with input false.
// - Live mode: blocked while input true, released when false.
// - Off mode: blocking input has no effect.
// - Assigning pin 3 via output settings forces positive polarity.
// - Clear after input removed releases blocking, channels restore state.
`timescale 1ns/1ps
`default_nettype none
`include "digital_port_params.svh"

module digital_port
	import digital_port_pkg::*;
#(
	parameter int LATENCY_CYCLES = `BLOCK_LATENCY_CYC,
	parameter int SHUTOFF_CYCLES = `SHUTOFF_CYC
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	input wire logic [2:0] chan_ov,
	input wire logic [2:0] chan_oc,
	input wire logic [2:0] chan_ot,
	input wire logic [1:0] nv_mode_in,
	output logic [1:0] nv_mode_out,
	output logic nv_save,
	output logic outputs_blocked,
	output logic fault_active,
	output logic prot_clear
);
	port_state_s r;
	port_state_s n;
	block_if blk();
	wire [2:0] sense;
	wire [2:0] oe_req;
	wire [2:0] bit_req;
	wire [2:0] in_word;
	wire [2:0] func_ok;
	wire [2:0] bidir_mask;
	wire [2:0] inonly_mask;
	wire [5:0] func_mask;

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_pin
			pin_func_e f;
			pin_func_e wf;
			logic quiet;
			assign f = pin_func_e'(r.func[2*i+:2]);
			assign wf = pin_func_e'(hwdata[2*i+:2]);
			assign func_ok[i] = !((wf == fault_signal_pin_function && i != 0)
				|| (wf == output_block_pin_function && i != 2));
			assign func_mask[2*i+:2] = {2{func_ok[i]}};
			// Pin 2 is the return of the fault output, so it must stay undriven
			assign quiet = (i == 1) && (r.func[1:0] == fault_signal_pin_function);
			assign bidir_mask[i] = (f == general_bidir_pin_function) && !quiet;
			assign inonly_mask[i] = (f == input_only_pin_function) && !quiet;
			assign oe_req[i] = bidir_mask[i] || (f == fault_signal_pin_function);
			assign bit_req[i] = (f == fault_signal_pin_function) ? blk.fault
				: r.out_word[i];
			assign in_word[i] = (bidir_mask[i] || inonly_mask[i]) ? sense[i]
				: 1'b0;
			pin_cell u_pin (
				.clock(clock),
				.nrst(nrst),
				.pin_in(pin_in[i]),
				.neg(r.neg[i]),
				.oe_req(oe_req[i]),
				.bit_req(bit_req[i]),
				.pin_out(pin_out[i]),
				.pin_oe(pin_oe[i]),
				.sense(sense[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// Blocking input and fault latch
	// ----------------------------------------
	assign blk.mode = r.mode;
	// Level sensed, so a held input keeps live mode blocked
	assign blk.block_true = (r.func[5:4] == output_block_pin_function) && sense[2];
	assign blk.clear = r.clear;
	assign blk.chan_cause = |{chan_ov, chan_oc, chan_ot};

	block_ctrl u_block (
		.clock(clock),
		.nrst(nrst),
		.bus(blk)
	);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] rv;
		logic [3:0] st;
		rv = 32'h0;
		st = 4'h0;
		st[`STAT_BT_BIT] = blk.block_true;
		st[`STAT_STICKY_BIT] = blk.sticky;
		st[`STAT_FAULT_BIT] = blk.fault;
		st[`STAT_BLOCKED_BIT] = blk.blocked;
		n = r;
		n.clear = 1'b0;
		n.nv_save = 1'b0;
		n.wr_pend = 1'b0;
		if (!r.loaded)
		begin
			n.loaded = 1'b1;
			n.mode = (nv_mode_in == `MODE_INVALID) ? block_mode_off
				: block_mode_e'(nv_mode_in);
		end
		if (r.wr_pend && r.wr_map)
		begin
			case (r.wr_off)
				`REG_FUNC_OFF: n.func = (hwdata[5:0] & func_mask)
					| (r.func & ~func_mask);
				`REG_POL_OFF: n.neg = hwdata[2:0];
				`REG_OUT_OFF: n.out_word = hwdata[2:0];
				`REG_MODE_OFF:
				begin
					if (hwdata[1:0] != `MODE_INVALID)
					begin
						n.mode = block_mode_e'(hwdata[1:0]);
						n.nv_save = 1'b1;
					end
				end
				`REG_OUTSET_OFF:
				begin
					if (hwdata[`OUTSET_ASSIGN_BIT])
					begin
						n.func[5:4] = output_block_pin_function;
						n.neg[2] = 1'b0;
					end
				end
				`REG_CLEAR_OFF: n.clear = hwdata[`CLEAR_BIT];
				default: ;
			endcase
		end
		if (r.rd_map)
		begin
			case (r.rd_off)
				`REG_FUNC_OFF: rv = {26'h0, r.func};
				`REG_POL_OFF: rv = {29'h0, r.neg};
				`REG_OUT_OFF: rv = {29'h0, r.out_word};
				`REG_IN_OFF: rv = {29'h0, in_word};
				`REG_MODE_OFF: rv = {30'h0, r.mode};
				`REG_STATUS_OFF: rv = {28'h0, st};
				default: rv = 32'h0;
			endcase
		end
		// Reads take one wait state so the data always reflects a write just before
		if (r.rd_pend)
		begin
			n.rdata = rv;
			n.ready = 1'b1;
			n.rd_pend = 1'b0;
		end
		if (hsel && htrans[1] && hready)
		begin
			if (hwrite)
			begin
				n.wr_pend = 1'b1;
				n.wr_map = (haddr[31:8] == 24'h0);
				n.wr_off = haddr[7:0];
			end
			else
			begin
				n.rd_pend = 1'b1;
				n.ready = 1'b0;
				n.rd_map = (haddr[31:8] == 24'h0);
				n.rd_off = haddr[7:0];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			r <= '0;
			r.func <= `FUNC_RESET;
			r.neg <= `POL_RESET;
			r.out_word <= `OUT_RESET;
			r.mode <= block_mode_off;
			r.ready <= 1'b1;
		end
		else
			r <= n;
	end

	assign hrdata = r.rdata;
	assign hreadyout = r.ready;
	assign hresp = r.resp;
	assign nv_mode_out = r.mode;
	assign nv_save = r.nv_save;
	assign outputs_blocked = blk.blocked;
	assign fault_active = blk.fault;
	assign prot_clear = r.clear;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [19:0] lat_cnt;
	always_ff @(posedge clock)
	begin
		if (!nrst)
			lat_cnt <= 20'h0;
		else if (r.mode == block_mode_live && blk.block_true && !blk.blocked)
			lat_cnt <= lat_cnt + 20'h1;
		else
			lat_cnt <= 20'h0;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence s_func_wr;
		r.wr_pend && r.wr_map && r.wr_off == `REG_FUNC_OFF;
	endsequence
	sequence s_outset_wr;
		r.wr_pend && r.wr_map && r.wr_off == `REG_OUTSET_OFF && hwdata[`OUTSET_ASSIGN_BIT];
	endsequence
	sequence s_mode_wr;
		r.wr_pend && r.wr_map && r.wr_off == `REG_MODE_OFF && hwdata[1:0] != `MODE_INVALID;
	endsequence
	sequence s_clear_wr;
		r.wr_pend && r.wr_map && r.wr_off == `REG_CLEAR_OFF && hwdata[`CLEAR_BIT];
	endsequence
	sequence s_out_wr;
		r.wr_pend && r.wr_map && r.wr_off == `REG_OUT_OFF;
	endsequence
	sequence s_in_rd;
		r.rd_pend && r.rd_map && r.rd_off == `REG_IN_OFF;
	endsequence

	property p_inonly;
		|inonly_mask |=> (pin_oe & $past(inonly_mask)) == 3'h0;
	endproperty
	a_inonly: assert property (p_inonly) else $error("input-only pin driven");

	property p_pos_drive;
		|(bidir_mask & ~r.neg) |=> (pin_oe & $past(bidir_mask & ~r.neg))
			== $past(bidir_mask & ~r.neg) && ((pin_out ^ $past(r.out_word))
			& $past(bidir_mask & ~r.neg)) == 3'h0;
	endproperty
	a_pos_drive: assert property (p_pos_drive) else $error("positive drive wrong");

	property p_neg_drive;
		|(bidir_mask & r.neg) |=> ((pin_out ^ ~$past(r.out_word))
			& $past(bidir_mask & r.neg)) == 3'h0;
	endproperty
	a_neg_drive: assert property (p_neg_drive) else $error("negative drive wrong");

	property p_pin2_quiet;
		r.func[1:0] == fault_signal_pin_function |=> !pin_oe[1];
	endproperty
	a_pin2_quiet: assert property (p_pin2_quiet) else $error("pin 2 driven");

	property p_fault_pin;
		r.func[1:0] == fault_signal_pin_function |=> pin_oe[0]
			&& pin_out[0] == ($past(blk.fault) ^ $past(r.neg[0]));
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault pin wrong");

	property p_reject;
		s_func_wr ##0 hwdata[3:2] == fault_signal_pin_function
			|=> r.func[3:2] == $past(r.func[3:2]);
	endproperty
	a_reject: assert property (p_reject) else $error("bad function taken");

	property p_outset;
		s_outset_wr |=> r.func[5:4] == output_block_pin_function && !r.neg[2];
	endproperty
	a_outset: assert property (p_outset) else $error("output settings path wrong");

	property p_nv;
		s_mode_wr |=> nv_save && nv_mode_out == $past(hwdata[1:0]);
	endproperty
	a_nv: assert property (p_nv) else $error("mode not saved");

	property p_latency;
		lat_cnt < LATENCY_CYCLES;
	endproperty
	a_latency: assert property (p_latency) else $error("blocking too slow");

	property p_shutoff;
		lat_cnt < SHUTOFF_CYCLES;
	endproperty
	a_shutoff: assert property (p_shutoff) else $error("shutoff too slow");

	property p_clear_pulse;
		s_clear_wr |=> prot_clear;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("no clear pulse");

	property p_out_word;
		s_out_wr |=> r.out_word == $past(hwdata[2:0]);
	endproperty
	a_out_word: assert property (p_out_word) else $error("output word not taken");

	property p_in_word;
		s_in_rd |=> (hrdata[2:0] & $past(bidir_mask | inonly_mask))
			== ($past(sense) & $past(bidir_mask | inonly_mask));
	endproperty
	a_in_word: assert property (p_in_word) else $error("input word wrong");

	// Refused requests must never leave a function on a pin that cannot carry it
	property p_func_legal;
		r.func[3:2] != fault_signal_pin_function && r.func[5:4] != fault_signal_pin_function
			&& r.func[1:0] != output_block_pin_function
			&& r.func[3:2] != output_block_pin_function;
	endproperty
	a_func_legal: assert property (p_func_legal) else $error("function on wrong pin");
endmodule : digital_port

`default_nettype wire

// [test/pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	input wire logic [2:0] ext_drv,
	input wire logic [2:0] ext_val,
	output logic [2:0] pin_in
);
	// ----------------------------------------
	// Wire level of each pin
	// ----------------------------------------
	// A pin nobody drives is held high by the pull-up, never left at the last
	// level; a closed switch or relay shorts the pin to common.
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_drv[i])
				pin_in[i] = ext_val[i];
			else
				pin_in[i] = 1'b1;
		end
	end
endmodule : pin_partner

`default_nettype wire

// [test/test_digital_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "digital_port_params.svh"

module test_digital_port;
	import digital_port_pkg::*;
	logic clock, nrst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, nv_mode_in, nv_mode_out;
	logic [2:0] hsize, pin_in, pin_out, pin_oe, chan_ov, chan_oc, chan_ot, ext_drv, ext_val;
	logic nv_save, outputs_blocked, fault_active, prot_clear;
	int errors, total_checks, cycles, clr_seen, save_seen;

	digital_port #(.LATENCY_CYCLES(20), .SHUTOFF_CYCLES(40)) DUT (.clock(clock), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.chan_ov(chan_ov), .chan_oc(chan_oc), .chan_ot(chan_ot), .nv_mode_in(nv_mode_in),
		.nv_mode_out(nv_mode_out), .nv_save(nv_save), .outputs_blocked(outputs_blocked),
		.fault_active(fault_active), .prot_clear(prot_clear));

	pin_partner partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
		.ext_val(ext_val), .pin_in(pin_in));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always @(posedge clock)
	begin
		cycles++;
		if (prot_clear === 1'b1)
			clr_seen++;
		if (nv_save === 1'b1)
			save_seen++;
		if (cycles == 20000)
		begin
			errors++;
			$display("[ERR] %0t run did not finish in time", $time);
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask : idle

	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd

	task automatic wait_blk(input logic want);
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (outputs_blocked === want)
				break;
		end
		check(outputs_blocked, want);
	endtask : wait_blk

	task automatic set_switch(input logic closed);
		@(posedge clock);
		ext_drv <= {closed, 2'b00};
		ext_val <= 3'h0;
	endtask : set_switch

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(nv_mode_out, 32'h2);
		check(pin_oe, 32'h0);
		rd(`REG_FUNC_OFF, 32'h15);
		rd(`REG_POL_OFF, 32'h0);
		wr(`REG_MODE_OFF, 32'h0);
		idle(2);
		check(nv_mode_out, 32'h0);
		check(save_seen, 32'h1);
	endtask : t_reset

	task automatic t_bidir();
		wr(`REG_FUNC_OFF, 32'h0);
		wr(`REG_OUT_OFF, 32'h5);
		idle(3);
		check(pin_oe, 32'h7);
		check(pin_out, 32'h5);
		wr(`REG_OUT_OFF, 32'h7);
		idle(3);
		check(pin_out, 32'h7);
		rd(`REG_IN_OFF, 32'h7);
		wr(`REG_OUT_OFF, 32'h6);
		wr(`REG_POL_OFF, 32'h5);
		idle(4);
		check(pin_out, 32'h3);
		rd(`REG_IN_OFF, 32'h6);
	endtask : t_bidir

	task automatic t_inonly();
		wr(`REG_FUNC_OFF, 32'h15);
		wr(`REG_POL_OFF, 32'h0);
		wr(`REG_OUT_OFF, 32'h7);
		ext_drv <= 3'h7;
		ext_val <= 3'h5;
		idle(4);
		check(pin_oe, 32'h0);
		rd(`REG_IN_OFF, 32'h5);
		wr(`REG_POL_OFF, 32'h3);
		idle(4);
		rd(`REG_IN_OFF, 32'h6);
		ext_drv <= 3'h0;
	endtask : t_inonly

	task automatic t_refuse();
		wr(`REG_FUNC_OFF, 32'h2B);
		rd(`REG_FUNC_OFF, 32'h15);
		wr(`REG_FUNC_OFF, 32'h36);
		rd(`REG_FUNC_OFF, 32'h36);
	endtask : t_refuse

	task automatic t_fault();
		wr(`REG_POL_OFF, 32'h0);
		idle(3);
		check(pin_oe[1:0], 32'h1);
		for (int k = 0; k < 3; k++)
		begin
			{chan_ot, chan_oc, chan_ov} <= 9'h001 << (k * 4);
			idle(1);
			{chan_ot, chan_oc, chan_ov} <= 9'h000;
			idle(4);
			check(fault_active, 32'h1);
			check(pin_out[0], 32'h1);
			wr(`REG_CLEAR_OFF, 32'h1);
			idle(3);
			check(fault_active, 32'h0);
		end
		// A clear while the cause stays must not drop the fault
		chan_ov <= 3'h1;
		idle(2);
		wr(`REG_CLEAR_OFF, 32'h1);
		idle(3);
		check(fault_active, 32'h1);
		chan_ov <= 3'h0;
		wr(`REG_CLEAR_OFF, 32'h1);
		wr(`REG_POL_OFF, 32'h1);
		idle(3);
		check(pin_out[0], 32'h1);
	endtask : t_fault

	task automatic t_live();
		wr(`REG_POL_OFF, 32'h7);
		wr(`REG_MODE_OFF, 32'h1);
		idle(2);
		check(nv_mode_out, 32'h1);
		set_switch(1'b1);
		wait_blk(1'b1);
		rd(`REG_STATUS_OFF, 32'hD);
		check(pin_out[0], 32'h0);
		set_switch(1'b0);
		wait_blk(1'b0);
		check(fault_active, 32'h1);
		wr(`REG_CLEAR_OFF, 32'h1);
		idle(3);
		check(fault_active, 32'h0);
	endtask : t_live

	task automatic t_sticky();
		int c;
		wr(`REG_MODE_OFF, 32'h2);
		set_switch(1'b1);
		wait_blk(1'b1);
		wr(`REG_CLEAR_OFF, 32'h1);
		idle(3);
		check(outputs_blocked, 32'h1);
		set_switch(1'b0);
		idle(10);
		check(outputs_blocked, 32'h1);
		rd(`REG_STATUS_OFF, 32'hE);
		c = clr_seen;
		wr(`REG_CLEAR_OFF, 32'h1);
		idle(3);
		check(clr_seen, c + 1);
		check(outputs_blocked, 32'h0);
	endtask : t_sticky

	task automatic t_off();
		wr(`REG_MODE_OFF, 32'h0);
		wr(`REG_CLEAR_OFF, 32'h1);
		set_switch(1'b1);
		idle(30);
		check(outputs_blocked, 32'h0);
		set_switch(1'b0);
	endtask : t_off

	task automatic t_outset();
		wr(`REG_FUNC_OFF, 32'h16);
		wr(`REG_POL_OFF, 32'h4);
		wr(`REG_OUTSET_OFF, 32'h1);
		rd(`REG_FUNC_OFF, 32'h36);
		rd(`REG_POL_OFF, 32'h0);
		rd(`REG_OUTSET_OFF, 32'h0);
		wr(`REG_MODE_OFF, 32'h3);
		rd(`REG_MODE_OFF, 32'h0);
		wr(32'h100, 32'h7);
		rd(32'h100, 32'h0);
		check(hresp, 32'h0);
	endtask : t_outset

	// Mid-run reset with an invalid stored mode: it must come back as off, with no save pulse
	task automatic t_reload();
		int c;
		c = save_seen;
		nv_mode_in <= 2'h3;
		nrst <= 1'b0;
		idle(3);
		nrst <= 1'b1;
		idle(1);
		check(pin_oe, 32'h0);
		check(fault_active, 32'h0);
		idle(1);
		check(nv_mode_out, 32'h0);
		check(save_seen, c);
		rd(`REG_FUNC_OFF, 32'h15);
		check(outputs_blocked, 32'h0);
		nv_mode_in <= 2'h2;
	endtask : t_reload

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		chan_ov = 3'h0;
		chan_oc = 3'h0;
		chan_ot = 3'h0;
		nv_mode_in = 2'h2;
		ext_drv = 3'h0;
		ext_val = 3'h0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		idle(2);
		t_reset();
		t_bidir();
		t_inonly();
		t_refuse();
		t_fault();
		t_live();
		t_sticky();
		t_off();
		t_outset();
		t_reload();
		stop_test();
	end
endmodule : test_digital_port

`default_nettype wire
